// [rtl/exec_map.svh]
// Register offsets, field positions, reset values and opcode patterns of the execute block.
// Assumes inclusion by bare name from the package and design files.
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
// =====================================================
// Register offsets (byte addresses)
`define OFS_INSTR 8'h00
`define OFS_STATUS 8'h04
`define OFS_ACC 8'h08
`define OFS_OPTION 8'h0C
`define OFS_DIR5 8'h10
`define OFS_DIR6 8'h14
`define OFS_DIR7 8'h18
`define OFS_STACK 8'h1C
`define OFS_PC 8'h20
`define OFS_IRQ 8'h24
`define OFS_FIDX 8'h28
`define OFS_FDATA 8'h2C
// =====================================================
// Field positions
`define ST_BUSY 0
`define ST_CARRY 1
`define ST_NIBBLE 2
`define ST_ZERO 3
`define ST_ILLEGAL 4
`define IRQ_GIE 7
// =====================================================
// Reset values and constants
`define RST_BYTE 8'h00
`define RST_OPTION 8'hFF
`define RST_DIR 8'hFF
`define RST_PC 13'h0000
`define IRQ_VECTOR 13'h0004
`define LAST_PHASE 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// =====================================================
// Opcode patterns
`define OPC_ADD_LIT 5'h1F
`define OPC_AND_LIT 6'h39
`define OPC_ADD_FILE 6'h07
`define OPC_AND_FILE 6'h05
`define OPC_SUB_FILE 6'h02
`define OPC_SWAP_FILE 6'h0E
`define OPC_RETURN_IRQ 14'h0009
`define OPC_OPTION 14'h0062
`define OPC_DIR_LOAD 11'h00C
`define DIR_FIRST 3'h5
`define DIR_LAST 3'h7
`endif

// [rtl/exec_pkg.sv]
// Types shared by the execute block and its arithmetic unit.
// Assumes exec_map.svh is on the include path.
`include "exec_map.svh"
package exec_pkg;
  // =====================================================
  // Arithmetic operations.
  typedef enum logic [2:0] {
    ALU_ADD = 3'b000,
    ALU_SUB = 3'b001,
    ALU_AND = 3'b010,
    ALU_SWAP = 3'b011,
    ALU_PASS = 3'b100
  } alu_op_type;
  // Engine states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10
  } state_type;
  // Decoded instruction classes.
  typedef enum logic [3:0] {
    I_NOP = 4'b0000,
    I_ADD_LIT = 4'b0001,
    I_AND_LIT = 4'b0010,
    I_ADD_FILE = 4'b0011,
    I_AND_FILE = 4'b0100,
    I_SUB_FILE = 4'b0101,
    I_SWAP_FILE = 4'b0110,
    I_RETURN_IRQ = 4'b0111,
    I_OPTION = 4'b1000,
    I_DIR_LOAD = 4'b1001,
    I_BAD = 4'b1010
  } insn_type;
endpackage

// [rtl/alu_if.sv]
// Carrier between the execute engine and its arithmetic unit.
// Assumes a purely combinational unit on the far side.
`timescale 1ns/1ns
interface alu_if;
  import exec_pkg::*;
  alu_op_type op;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] result;
  logic carry;
  logic nibble;
  logic zero;
  modport engine (output op, output a, output b, input result, input carry, input nibble, input zero);
  modport unit (input op, input a, input b, output result, output carry, output nibble, output zero);
endinterface

// [rtl/exec_alu.sv]
// Eight-bit arithmetic unit: add, subtract, AND, nibble swap and pass.
// Assumes operands stay stable while the engine samples the result.
`timescale 1ns/1ns
module exec_alu
  import exec_pkg::*;
(
  alu_if.unit bus // Operands in, result and flags out.
);
  logic [8:0] sum;
  logic [4:0] low;

  // =====================================================
  // Datapath
  // Subtraction adds the inverted operand plus one, so carry out means no borrow.
  always_comb begin
    sum = 9'h000;
    low = 5'h00;
    bus.result = bus.a;
    case (bus.op)
      ALU_ADD: begin
        sum = {1'b0, bus.a} + {1'b0, bus.b};
        low = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
        bus.result = sum[7:0];
      end
      ALU_SUB: begin
        sum = {1'b0, bus.a} + {1'b0, ~bus.b} + 9'h001; // [RULE_08]
        low = {1'b0, bus.a[3:0]} + {1'b0, ~bus.b[3:0]} + 5'h01;
        bus.result = sum[7:0];
      end
      ALU_AND: bus.result = bus.a & bus.b;
      ALU_SWAP: bus.result = {bus.a[3:0], bus.a[7:4]}; // [RULE_10]
      default: bus.result = bus.a;
    endcase
  end

  // Flags; carry set on no borrow and zero only on an all-zero result.
  assign bus.carry = sum[8]; // [RULE_09]
  assign bus.nibble = low[4];
  assign bus.zero = (bus.result == 8'h00); // [RULE_09]
endmodule // exec_alu

// [rtl/instruction_execute.sv]
// Execute engine for a subset of a 14-bit instruction set, with an AXI4-Lite register slave.
// Assumes one clock; software loads one instruction word at a time and polls busy.
//
// Behaviour
// RULE_01 - Add-immediate: accumulator plus literal into accumulator; carry, nibble and zero updated.
// RULE_02 - Add-to-file: accumulator plus file register, flags updated, one instruction cycle.
// RULE_03 - Target bit 0 sends result to accumulator, 1 back to the file register.
// RULE_04 - AND-immediate: accumulator AND literal into accumulator; only zero flag updated.
// RULE_05 - AND-with-file: accumulator AND file register to target; only zero updated.
// RULE_06 - Return from interrupt: pop stack to counter, set enable, two cycles, flags kept.
// RULE_07 - Option load: accumulator into option register, one cycle, flags untouched.
// RULE_08 - Subtract: file register minus accumulator, two's complement, to target, flags updated.
// RULE_09 - Subtract carry means no borrow; zero only when difference is zero.
// RULE_10 - Nibble exchange of file register to target, flags untouched.
// RULE_11 - Direction load copies accumulator to direction register 5 to 7, flags untouched.
// RULE_12 - Four phases: decode, operand read, process, write-back.
// RULE_13 - Global enable is bit 7 of irq control; vector when pending and unmasked.
`timescale 1ns/1ns
`include "exec_map.svh"
module instruction_execute
  import exec_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  input wire logic aclk, // Core clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [7:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  input wire logic [2:0] irq_event, // Interrupt source pulses.
  output logic [7:0] option_value, // Option configuration register.
  output logic [7:0] port_dir_5, // Direction register 5.
  output logic [7:0] port_dir_6, // Direction register 6.
  output logic [7:0] port_dir_7, // Direction register 7.
  output logic global_irq_enable, // Global interrupt enable.
  output logic busy // Engine is running or has a word queued.
);
  // =====================================================
  // Declarations
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_full;
  logic w_full;
  logic do_write;
  logic [31:0] wval;
  logic [13:0] instr;
  logic start_pending;
  state_type state;
  logic [1:0] phase;
  insn_type cls;
  logic [7:0] operand;
  logic [7:0] result;
  logic res_carry;
  logic res_nibble;
  logic res_zero;
  logic [7:0] acc;
  logic carry_flag;
  logic nibble_borrow_flag;
  logic zero_flag;
  logic illegal_flag;
  logic [7:0] file_mem [FILE_DEPTH];
  logic [6:0] file_index;
  logic [12:0] program_counter;
  logic [12:0] stack_top;
  logic [5:0] irq_bits;
  logic vector_now;
  logic idle;
  logic in_write;
  logic target_file;
  logic [6:0] file_addr;
  alu_if alu ();

  // Merges the written word into the old value lane by lane.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Classifies an instruction word; the option pattern is checked before the direction pattern it overlaps.
  function automatic insn_type decode(input logic [13:0] w);
    insn_type c;
    c = I_BAD;
    if (w[13:9] == `OPC_ADD_LIT) c = I_ADD_LIT; // [RULE_01]
    else if (w[13:8] == `OPC_AND_LIT) c = I_AND_LIT; // [RULE_04]
    else if (w[13:8] == `OPC_ADD_FILE) c = I_ADD_FILE; // [RULE_02]
    else if (w[13:8] == `OPC_AND_FILE) c = I_AND_FILE; // [RULE_05]
    else if (w[13:8] == `OPC_SUB_FILE) c = I_SUB_FILE; // [RULE_08]
    else if (w[13:8] == `OPC_SWAP_FILE) c = I_SWAP_FILE; // [RULE_10]
    else if (w == `OPC_RETURN_IRQ) c = I_RETURN_IRQ; // [RULE_06]
    else if (w == `OPC_OPTION) c = I_OPTION; // [RULE_07]
    else if (w[13:3] == `OPC_DIR_LOAD) c = I_DIR_LOAD; // [RULE_11]
    else if (w[13:7] == 7'h00 && w[4:0] == 5'h00) c = I_NOP;
    return c;
  endfunction

  // =====================================================
  // Shared terms
  assign idle = (state == ST_IDLE);
  assign do_write = aw_full && w_full && !bvalid;
  assign in_write = do_write && idle && !start_pending;
  assign wval = w_data;
  assign target_file = instr[7];
  assign file_addr = instr[6:0];
  // Vectoring waits for an idle engine so an instruction is never cut in half.
  assign vector_now = idle && !start_pending && global_irq_enable && |(irq_bits[2:0] & irq_bits[5:3]); // [RULE_13]

  // =====================================================
  // AXI4-Lite write channel
  // Address and data are taken in either order; the response follows one cycle after both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_full <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_full <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        case (aw_addr)
          `OFS_INSTR: bresp <= (idle && !start_pending) ? `RESP_OKAY : `RESP_SLVERR;
          `OFS_STATUS, `OFS_ACC, `OFS_OPTION, `OFS_DIR5, `OFS_DIR6, `OFS_DIR7,
          `OFS_STACK, `OFS_PC, `OFS_IRQ, `OFS_FIDX, `OFS_FDATA: bresp <= `RESP_OKAY;
          default: bresp <= `RESP_SLVERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // =====================================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `RESP_OKAY;
        case (araddr)
          `OFS_INSTR: rdata <= {18'h0, instr};
          `OFS_STATUS: rdata <= {27'h0, illegal_flag, zero_flag, nibble_borrow_flag, carry_flag, busy};
          `OFS_ACC: rdata <= {24'h000000, acc};
          `OFS_OPTION: rdata <= {24'h000000, option_value};
          `OFS_DIR5: rdata <= {24'h000000, port_dir_5};
          `OFS_DIR6: rdata <= {24'h000000, port_dir_6};
          `OFS_DIR7: rdata <= {24'h000000, port_dir_7};
          `OFS_STACK: rdata <= {19'h0, stack_top};
          `OFS_PC: rdata <= {19'h0, program_counter};
          `OFS_IRQ: rdata <= {24'h000000, global_irq_enable, 1'b0, irq_bits};
          `OFS_FIDX: rdata <= {25'h0, file_index};
          `OFS_FDATA: rdata <= {24'h000000, file_mem[file_index]};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // =====================================================
  // Instruction word and start request
  // Writes while busy are refused so a running instruction never sees its word change.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr <= 14'h0000;
      start_pending <= 1'b0;
    end else if (in_write && aw_addr == `OFS_INSTR) begin
      instr <= 14'(merge({18'h0, instr}, wval, w_strb));
      start_pending <= 1'b1;
    end else if (idle && start_pending) begin
      start_pending <= 1'b0;
    end
  end

  // Busy mirrors the engine and any queued word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (in_write && aw_addr == `OFS_INSTR) || start_pending || !idle;
    end
  end

  // =====================================================
  // Phase sequencer
  // Each instruction cycle is four clocks; the return from interrupt adds a fully idle cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      phase <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          phase <= 2'h0;
          if (start_pending) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          phase <= phase + 2'h1; // [RULE_12]
          if (phase == `LAST_PHASE) begin
            state <= (cls == I_RETURN_IRQ) ? ST_WAIT : ST_IDLE; // [RULE_06]
          end
        end
        ST_WAIT: begin
          phase <= phase + 2'h1;
          if (phase == `LAST_PHASE) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // =====================================================
  // Decode, operand read and processing phases
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cls <= I_NOP;
      operand <= 8'h00;
      result <= 8'h00;
      res_carry <= 1'b0;
      res_nibble <= 1'b0;
      res_zero <= 1'b0;
    end else if (state == ST_EXEC) begin
      case (phase)
        2'h0: cls <= decode(instr); // [RULE_12]
        2'h1: operand <= (cls == I_ADD_LIT || cls == I_AND_LIT) ? instr[7:0] : file_mem[file_addr];
        2'h2: begin
          result <= alu.result;
          res_carry <= alu.carry;
          res_nibble <= alu.nibble;
          res_zero <= alu.zero;
        end
        default: ;
      endcase
    end
  end

  // Operand routing into the arithmetic unit; subtraction takes the file operand first.
  always_comb begin
    alu.op = ALU_PASS;
    alu.a = acc;
    alu.b = operand;
    case (cls)
      I_ADD_LIT, I_ADD_FILE: alu.op = ALU_ADD;
      I_AND_LIT, I_AND_FILE: alu.op = ALU_AND;
      I_SUB_FILE: begin
        alu.op = ALU_SUB;
        alu.a = operand; // [RULE_08]
        alu.b = acc;
      end
      I_SWAP_FILE: begin
        alu.op = ALU_SWAP;
        alu.a = operand;
      end
      default: alu.op = ALU_PASS;
    endcase
  end

  exec_alu alu_unit (
    .bus(alu.unit)
  );

  // =====================================================
  // Accumulator write-back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= `RST_BYTE;
    end else if (state == ST_EXEC && phase == `LAST_PHASE) begin
      case (cls)
        I_ADD_LIT, I_AND_LIT: acc <= result; // [RULE_01] [RULE_04]
        I_ADD_FILE, I_AND_FILE, I_SUB_FILE, I_SWAP_FILE: begin
          if (!target_file) begin
            acc <= result; // [RULE_03]
          end
        end
        default: ;
      endcase
    end else if (in_write && aw_addr == `OFS_ACC) begin
      acc <= 8'(merge({24'h0, acc}, wval, w_strb));
    end
  end

  // =====================================================
  // File registers and software window index
  // The window index lets software preload and inspect operands without a wide address map.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      file_index <= 7'h00;
    end else if (in_write && aw_addr == `OFS_FIDX) begin
      file_index <= 7'(merge({25'h0, file_index}, wval, w_strb));
    end
  end

  always_ff @(posedge aclk) begin
    if (state == ST_EXEC && phase == `LAST_PHASE && target_file &&
        (cls == I_ADD_FILE || cls == I_AND_FILE || cls == I_SUB_FILE || cls == I_SWAP_FILE)) begin
      file_mem[file_addr] <= result; // [RULE_03]
    end else if (in_write && aw_addr == `OFS_FDATA) begin
      file_mem[file_index] <= 8'(merge({24'h0, file_mem[file_index]}, wval, w_strb));
    end
  end

  // =====================================================
  // Status flags
  // Swap, return and option loads fall through and leave every flag alone; a direction load sets only the illegal flag, for a selector below 5.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_flag <= 1'b0;
      nibble_borrow_flag <= 1'b0;
      zero_flag <= 1'b0;
      illegal_flag <= 1'b0;
    end else if (state == ST_EXEC && phase == `LAST_PHASE) begin
      case (cls)
        I_ADD_LIT, I_ADD_FILE, I_SUB_FILE: begin
          carry_flag <= res_carry; // [RULE_01] [RULE_02] [RULE_09]
          nibble_borrow_flag <= res_nibble;
          zero_flag <= res_zero;
        end
        I_AND_LIT, I_AND_FILE: zero_flag <= res_zero; // [RULE_04] [RULE_05]
        I_DIR_LOAD: begin
          if (instr[2:0] < `DIR_FIRST) begin
            illegal_flag <= 1'b1;
          end
        end
        I_BAD: illegal_flag <= 1'b1;
        default: ;
      endcase
    end else if (in_write && aw_addr == `OFS_STATUS && w_strb[0]) begin
      carry_flag <= wval[`ST_CARRY];
      nibble_borrow_flag <= wval[`ST_NIBBLE];
      zero_flag <= wval[`ST_ZERO];
      illegal_flag <= illegal_flag && !wval[`ST_ILLEGAL];
    end
  end

  // =====================================================
  // Option and direction registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_value <= `RST_OPTION;
      port_dir_5 <= `RST_DIR;
      port_dir_6 <= `RST_DIR;
      port_dir_7 <= `RST_DIR;
    end else if (state == ST_EXEC && phase == `LAST_PHASE) begin
      if (cls == I_OPTION) begin
        option_value <= acc; // [RULE_07]
      end
      if (cls == I_DIR_LOAD) begin
        case (instr[2:0])
          `DIR_FIRST: port_dir_5 <= acc; // [RULE_11]
          3'h6: port_dir_6 <= acc;
          `DIR_LAST: port_dir_7 <= acc;
          default: ;
        endcase
      end
    end else if (in_write) begin
      case (aw_addr)
        `OFS_OPTION: option_value <= 8'(merge({24'h0, option_value}, wval, w_strb));
        `OFS_DIR5: port_dir_5 <= 8'(merge({24'h0, port_dir_5}, wval, w_strb));
        `OFS_DIR6: port_dir_6 <= 8'(merge({24'h0, port_dir_6}, wval, w_strb));
        `OFS_DIR7: port_dir_7 <= 8'(merge({24'h0, port_dir_7}, wval, w_strb));
        default: ;
      endcase
    end
  end

  // =====================================================
  // Program counter and stack top
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_counter <= `RST_PC;
      stack_top <= `RST_PC;
    end else if (vector_now) begin
      stack_top <= program_counter; // [RULE_13]
      program_counter <= `IRQ_VECTOR;
    end else if (state == ST_EXEC && phase == `LAST_PHASE) begin
      if (cls == I_RETURN_IRQ) begin
        program_counter <= stack_top; // [RULE_06]
      end else begin
        program_counter <= program_counter + 13'h0001;
      end
    end else if (in_write && aw_addr == `OFS_PC) begin
      program_counter <= 13'(merge({19'h0, program_counter}, wval, w_strb));
    end else if (in_write && aw_addr == `OFS_STACK) begin
      stack_top <= 13'(merge({19'h0, stack_top}, wval, w_strb));
    end
  end

  // =====================================================
  // Interrupt control: flags [2:0], masks [5:3], global enable
  // A source pulse in the clearing cycle still lands, so no event is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_bits <= 6'h00;
      global_irq_enable <= 1'b0; // [RULE_13]
    end else begin
      if (in_write && aw_addr == `OFS_IRQ && w_strb[0]) begin
        irq_bits <= wval[5:0] | {3'h0, irq_event};
      end else begin
        irq_bits <= irq_bits | {3'h0, irq_event};
      end
      if (vector_now) begin
        global_irq_enable <= 1'b0; // [RULE_13]
      end else if (state == ST_EXEC && phase == 2'h2 && cls == I_RETURN_IRQ) begin
        global_irq_enable <= 1'b1; // [RULE_06]
      end else if (in_write && aw_addr == `OFS_IRQ && w_strb[0]) begin
        global_irq_enable <= wval[`IRQ_GIE];
      end
    end
  end
endmodule // instruction_execute

// [sim/exec_monitor.sv]
// Checker of the execute block's bus answers and register outputs.
// Assumes it is bound into instruction_execute.
`timescale 1ns/1ns
// ====
// Checker
module exec_monitor (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic awvalid, // In.
  input wire logic awready, // In.
  input wire logic wvalid, // In.
  input wire logic wready, // In.
  input wire logic bvalid, // In.
  input wire logic bready, // In.
  input wire logic [1:0] bresp, // In.
  input wire logic arvalid, // In.
  input wire logic arready, // In.
  input wire logic rvalid, // In.
  input wire logic rready, // In.
  input wire logic [31:0] rdata, // In.
  input wire logic [7:0] option_value, // In.
  input wire logic [7:0] port_dir_5, // In.
  input wire logic [7:0] port_dir_6, // In.
  input wire logic [7:0] port_dir_7, // In.
  input wire logic global_irq_enable, // In.
  input wire logic busy // In.
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Option, direction and a rising enable may move only under execution or right at a register write answer.
  AST_OPT_SRC: assert property ($changed(option_value) |-> $past(busy) || $rose(bvalid))
    else $error("option moved while idle");
  AST_DIR_SRC: assert property ($changed({port_dir_5, port_dir_6, port_dir_7}) |-> $past(busy) || $rose(bvalid))
    else $error("direction moved while idle");
  AST_GIE_SET: assert property ($rose(global_irq_enable) |-> $past(busy) || $rose(bvalid))
    else $error("enable rose while idle");
  AST_GIE_RST: assert property ($rose(aresetn) |-> !global_irq_enable)
    else $error("enable set after reset");
  AST_BUSY_END: assert property ($rose(busy) |-> ##[1:16] !busy)
    else $error("execution too long");
  // Read answers come one clock after the take, write answers two clocks after; both stand until taken.
  AST_B_NEXT: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("no write answer");
  AST_R_NEXT: assert property (arvalid && arready |=> rvalid)
    else $error("no read answer");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
endmodule // exec_monitor
bind instruction_execute exec_monitor u_mon (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .option_value, .port_dir_5, .port_dir_6,
  .port_dir_7, .global_irq_enable, .busy);

// [sim/program_store.sv]
// Program memory model that hands instruction words to the bench.
// Assumes indices 0 to 11 only.
`timescale 1ns/1ns
// ====
// Store
module program_store (
  input wire logic [3:0] idx, // Word index.
  output logic [13:0] word // Instruction word.
);
  // Fixed program; entry 0 sets the ignored bit to show it is don't-care.
  logic [13:0] mem [12] = '{14'h3F08, 14'h0585, 14'h3900, 14'h0705, 14'h0285, 14'h0E05,
    14'h0062, 14'h0064, 14'h0065, 14'h0066, 14'h0067, 14'h0009};
  assign word = mem[idx];
endmodule // program_store

// [sim/mcu_instruction_execute_subset_tb.sv]
// Bench that runs instructions through the register bus and checks results.
// Assumes the exec_map.svh offsets and a one-clock design.
`timescale 1ns/1ns
`include "exec_map.svh"
// ====
// Bench
module mcu_instruction_execute_subset_tb;
  logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [3:0] wstrb = 4'hF, pidx = 4'h0;
  logic [2:0] irq_event = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, global_irq_enable, busy;
  logic [1:0] bresp, rresp, r;
  logic [7:0] option_value, port_dir_5, port_dir_6, port_dir_7;
  logic [13:0] pword;
  logic [7:0] sub_res [3] = '{8'h01, 8'h00, 8'hFF};
  logic [3:0] sub_st [3] = '{4'h6, 4'hE, 4'h0};
  int bad_count = 0, num_checks = 0;
  instruction_execute u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq_event,
    .option_value, .port_dir_5, .port_dir_6, .port_dir_7, .global_irq_enable, .busy);
  program_store u_rom (.idx(pidx), .word(pword));
  // Clock of 20 ns.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Comparison and report.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bus master; ready rises once the answer is seen, so the slave must hold it a cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bready) break;
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rready) break;
      if (rvalid) rready <= 1'b1;
    end
    rready <= 1'b0;
    d = rdata;
    rs = rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v, r);
    chk(v, e);
  endtask
  // Fetch a word, start it and poll busy until it finishes.
  task automatic go(input int i);
    pidx = i[3:0];
    #1;
    wr(`OFS_INSTR, {18'h0, pword});
    do rd(`OFS_STATUS, v, r); while (v[`ST_BUSY] !== 1'b0);
  endtask
  // Main sequence.
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`OFS_OPTION, 32'hFF);
    chk(32'(global_irq_enable), 32'h0);
    rd(8'hF0, v, r);
    chk(32'(r), 32'(`RESP_SLVERR));
    wr(`OFS_FIDX, 32'h5);
    wr(`OFS_ACC, 32'hF8);
    go(0);
    rchk(`OFS_ACC, 32'h0);
    rchk(`OFS_STATUS, 32'hE);
    wr(`OFS_ACC, 32'h17);
    wr(`OFS_FDATA, 32'hC2);
    go(1);
    rchk(`OFS_FDATA, 32'h02);
    rchk(`OFS_STATUS, 32'h6);
    go(2);
    rchk(`OFS_ACC, 32'h0);
    rchk(`OFS_STATUS, 32'hE);
    wr(`OFS_ACC, 32'h17);
    wr(`OFS_FDATA, 32'hC2);
    go(3);
    rchk(`OFS_ACC, 32'hD9);
    rchk(`OFS_FDATA, 32'hC2);
    rchk(`OFS_STATUS, 32'h0);
    // Positive, zero and negative differences.
    for (int k = 0; k < 3; k++) begin
      wr(`OFS_ACC, 32'h2);
      wr(`OFS_FDATA, 32'(3 - k));
      go(4);
      rchk(`OFS_FDATA, 32'(sub_res[k]));
      rchk(`OFS_STATUS, 32'(sub_st[k]));
    end
    wr(`OFS_FDATA, 32'hA5);
    go(5);
    rchk(`OFS_ACC, 32'h5A);
    rchk(`OFS_STATUS, 32'h0);
    wr(`OFS_ACC, 32'h3C);
    go(6);
    chk(32'(option_value), 32'h3C);
    // Selector 4 is illegal; it sets only the illegal flag and leaves the direction registers alone.
    for (int f = 4; f < 8; f++) begin
      wr(`OFS_ACC, 32'(8'h40 + f));
      go(f + 3);
    end
    chk(32'({port_dir_7, port_dir_6, port_dir_5}), 32'h474645);
    rchk(`OFS_STATUS, 32'h10);
    wr(`OFS_STACK, 32'h123);
    go(11);
    chk(32'(global_irq_enable), 32'h1);
    rchk(`OFS_PC, 32'h123);
    irq_event <= 3'h1;
    wr(`OFS_IRQ, 32'h88);
    rchk(`OFS_PC, 32'h4);
    tally_and_finish;
  end
  // Watchdog; the tests need some hundreds of clocks, so 10,000 means a hang.
  initial begin
    #200000;
    bad_count++;
    tally_and_finish;
  end
endmodule // mcu_instruction_execute_subset_tb
